// ---- pwcc_top.sv ----
// power wake command controller: i2c slave, command decode, event timers
// assumes the host is i2c master; scl is the link clock, sda is open drain
`timescale 1ns/1ps
`include "pwcc_params.svh"
module pwcc_top #(
    parameter longint TICKS_PER_MIN = `PWCC_TICKS_PER_MIN
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_ring,
    input wire logic [3:0] i_wake_in,
    output logic o_power_off,
    output logic o_power_on,
    output logic [7:0] o_enable_map
);
    ////////////////////////////////////////////////////////////////////
    // link domain: i2c slave on scl, reset also by start/stop
    pwcc_pkg::pwcc_i2c_state_t st_r, st_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic rw_r, rw_nxt;
    logic ack_r, ack_nxt;
    logic first_r, first_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] wbyte_r, wbyte_nxt;
    logic wtgl_r, wtgl_nxt;
    logic wcmd_r, wcmd_nxt;
    logic start_r, stop_r;
    logic [7:0] rd_sync1_r, rd_sync2_r;
    logic sda_out_nxt;
    logic sda_oe_r; // pin enable straight from a flop

    // start toggles a flag on sda fall with scl high; stop toggles its own flag on sda rise
    always_ff @(negedge i_sda or negedge i_rstn) begin
        if (!i_rstn) begin
            start_r <= 1'b0;
        end else begin
            start_r <= i_scl ? ~start_r : start_r;
        end
    end
    always_ff @(posedge i_sda or negedge i_rstn) begin
        if (!i_rstn) begin
            stop_r <= 1'b0;
        end else begin
            stop_r <= i_scl ? ~stop_r : stop_r;
        end
    end

    logic seen_start_r, seen_stop_r;
    logic new_start, new_stop;
    assign new_start = (start_r != seen_start_r);
    assign new_stop = (stop_r != seen_stop_r);

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = {sh_r[6:0], i_sda};
        rw_nxt = rw_r;
        ack_nxt = 1'b0;
        first_nxt = first_r;
        cmd_nxt = cmd_r;
        wbyte_nxt = wbyte_r;
        wtgl_nxt = wtgl_r;
        wcmd_nxt = wcmd_r;
        if (new_start) begin
            st_nxt = pwcc_pkg::PWCC_ADDR;
            bit_nxt = 4'h1;
            sh_nxt = {7'h00, i_sda};
        end else if (new_stop) begin
            st_nxt = pwcc_pkg::PWCC_IDLE;
            bit_nxt = 4'h0;
        end else if (st_r != pwcc_pkg::PWCC_IDLE) begin
            bit_nxt = (bit_r == 4'h8) ? 4'h0 : 4'(bit_r + 4'h1);
            if (bit_r == 4'h7) begin
                if (st_r == pwcc_pkg::PWCC_ADDR) begin
                    ack_nxt = (sh_r[6:0] == `PWCC_I2C_ADDR);
                    rw_nxt = i_sda;
                    first_nxt = 1'b1;
                end else if (st_r == pwcc_pkg::PWCC_DATA) begin
                    ack_nxt = 1'b1;
                    if (first_r) begin
                        cmd_nxt = {sh_r[6:0], i_sda};
                        wcmd_nxt = 1'b1;
                    end else begin
                        wbyte_nxt = {sh_r[6:0], i_sda};
                        wcmd_nxt = 1'b0;
                    end
                    first_nxt = 1'b0;
                    wtgl_nxt = ~wtgl_r;
                end
            end
            if (bit_r == 4'h8) begin
                unique case (st_r)
                    pwcc_pkg::PWCC_ADDR: begin
                        st_nxt = !ack_r ? pwcc_pkg::PWCC_IDLE
                            : (rw_r ? pwcc_pkg::PWCC_READ : pwcc_pkg::PWCC_DATA);
                    end
                    pwcc_pkg::PWCC_READ: begin
                        // nack from master ends the read
                        st_nxt = i_sda ? pwcc_pkg::PWCC_IDLE : pwcc_pkg::PWCC_READ;
                    end
                    default: begin
                        st_nxt = st_r;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= pwcc_pkg::PWCC_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            first_r <= 1'b0;
            cmd_r <= 8'h00;
            wbyte_r <= 8'h00;
            wtgl_r <= 1'b0;
            wcmd_r <= 1'b0;
            seen_start_r <= 1'b0;
            seen_stop_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            first_r <= first_nxt;
            cmd_r <= cmd_nxt;
            wbyte_r <= wbyte_nxt;
            wtgl_r <= wtgl_nxt;
            wcmd_r <= wcmd_nxt;
            seen_start_r <= start_r;
            seen_stop_r <= stop_r;
        end
    end

    // answer byte comes from the core domain; it is static during a read
    always_ff @(posedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_sync1_r <= 8'h00;
            rd_sync2_r <= 8'h00;
        end else begin
            rd_sync1_r <= reply_r;
            rd_sync2_r <= rd_sync1_r;
        end
    end

    // drive one answer bit per falling scl
    always_comb begin
        sda_out_nxt = 1'b1;
        if (ack_r || (st_r == pwcc_pkg::PWCC_DATA && bit_r == 4'h8)) begin
            sda_out_nxt = 1'b0;
        end else if (st_r == pwcc_pkg::PWCC_READ && bit_r != 4'h8) begin
            sda_out_nxt = rd_sync2_r[3'(4'h7 - bit_r)];
        end
    end
    always_ff @(negedge i_scl or negedge i_rstn) begin
        if (!i_rstn) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= ~sda_out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core domain: byte toggle crossing and input synchronisers
    logic [2:0] tgl_sync_r;
    logic [4:0] in_s1_r, in_s2_r;
    logic [7:0] setup_cmd_r, setup_cmd_nxt;
    logic [7:0] reply_r, reply_nxt;
    logic [3:0] in_en_r, in_en_nxt;
    logic any_en_r, any_en_nxt;
    logic ring_armed_r, ring_armed_nxt;
    logic off_r, off_nxt, on_r, on_nxt;
    logic [32:0] tick_cnt_r, tick_cnt_nxt;
    logic min_tick;
    logic byte_evt;
    logic [3:0] ld;
    logic [3:0] fire;
    logic [7:0] tm [4];

    // toggle plus held byte: byte stable long before the toggle lands
    assign byte_evt = tgl_sync_r[2] ^ tgl_sync_r[1];

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tgl_sync_r <= 3'h0;
            in_s1_r <= 5'h00;
            in_s2_r <= 5'h00;
        end else begin
            tgl_sync_r <= {tgl_sync_r[1:0], wtgl_r};
            in_s1_r <= {i_ring, i_wake_in};
            in_s2_r <= in_s1_r;
        end
    end

    // minute tick prescaler
    assign min_tick = (tick_cnt_r == 33'(TICKS_PER_MIN - 1));
    assign tick_cnt_nxt = min_tick ? 33'h0_0000_0000 : 33'(tick_cnt_r + 33'h1);

    // decode helpers: load pulse for each timed event
    always_comb begin
        ld = 4'h0;
        if (byte_evt && !wcmd_r) begin
            ld[0] = (setup_cmd_r == `PWCC_CMD_OFF);
            ld[1] = (setup_cmd_r == `PWCC_CMD_RING);
            ld[2] = (setup_cmd_r == `PWCC_CMD_AFTER);
            ld[3] = (setup_cmd_r == `PWCC_CMD_EVERY);
        end
        if (byte_evt && !wcmd_r && setup_cmd_r == `PWCC_CMD_CLEAR) begin
            ld = 4'hf;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tmr
            pwcc_timer u_timer (
                .i_clock(i_clock),
                .i_rstn(i_rstn),
                .i_load(ld[gi]),
                .i_time((setup_cmd_r == `PWCC_CMD_CLEAR) ? `PWCC_TIME_OFF : wbyte_r),
                .i_reload(gi == 3),
                .i_min_tick(min_tick),
                .o_fire(fire[gi]),
                .o_time(tm[gi])
            );
        end
    endgenerate

    // command decode, wake logic and reply selection
    always_comb begin
        setup_cmd_nxt = setup_cmd_r;
        in_en_nxt = in_en_r;
        any_en_nxt = any_en_r;
        ring_armed_nxt = ring_armed_r;
        reply_nxt = reply_r;
        off_nxt = 1'b0;
        on_nxt = 1'b0;
        if (byte_evt && wcmd_r) begin
            setup_cmd_nxt = cmd_r;
            unique case (cmd_r)
                `PWCC_Q_OFF: reply_nxt = tm[0];
                `PWCC_Q_RING: reply_nxt = tm[1];
                `PWCC_Q_AFTER: reply_nxt = tm[2];
                `PWCC_Q_EVERY: reply_nxt = tm[3];
                `PWCC_Q_ENABLE: reply_nxt = o_enable_map;
                default: reply_nxt = reply_r;
            endcase
        end
        if (byte_evt && !wcmd_r) begin
            if (setup_cmd_r == `PWCC_CMD_ANY_IN) begin
                any_en_nxt = (wbyte_r == `PWCC_TIME_NOW);
            end
            if (setup_cmd_r >= `PWCC_CMD_IN0 && setup_cmd_r <= `PWCC_CMD_IN3) begin
                in_en_nxt[2'(setup_cmd_r - `PWCC_CMD_IN0)] = (wbyte_r == `PWCC_TIME_NOW);
            end
            if (setup_cmd_r == `PWCC_CMD_CLEAR) begin
                in_en_nxt = 4'h0;
                any_en_nxt = 1'b0;
            end
            if (setup_cmd_r == `PWCC_CMD_RING || setup_cmd_r == `PWCC_CMD_CLEAR) begin
                ring_armed_nxt = 1'b0;
            end
        end
        // power off when its timer fires
        off_nxt = fire[0];
        if (fire[1]) begin
            ring_armed_nxt = 1'b1;
        end
        on_nxt = fire[2] | fire[3] | (ring_armed_r & in_s2_r[4])
            | |(in_en_r & in_s2_r[3:0]) | (any_en_r & |in_s2_r[3:0]);
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            setup_cmd_r <= 8'h00;
            in_en_r <= 4'h0;
            any_en_r <= 1'b0;
            ring_armed_r <= 1'b0;
            reply_r <= 8'h00;
            off_r <= 1'b0;
            on_r <= 1'b0;
            tick_cnt_r <= 33'h0_0000_0000;
        end else begin
            setup_cmd_r <= setup_cmd_nxt;
            in_en_r <= in_en_nxt;
            any_en_r <= any_en_nxt;
            ring_armed_r <= ring_armed_nxt;
            reply_r <= reply_nxt;
            off_r <= off_nxt;
            on_r <= on_nxt;
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // enable map is registered from timer state and the next enable state
    logic [7:0] en_map_r;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            en_map_r <= 8'h00;
        end else begin
            // ring stays enabled after its delay has run out
            en_map_r <= {tm[0] != `PWCC_TIME_OFF,
                (tm[1] != `PWCC_TIME_OFF) | ring_armed_nxt,
                tm[2] != `PWCC_TIME_OFF, tm[3] != `PWCC_TIME_OFF,
                in_en_nxt | {4{any_en_nxt}}};
        end
    end

    assign o_enable_map = en_map_r;
    assign o_power_off = off_r;
    assign o_power_on = on_r;
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_oe_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_clear_disables;
        @(posedge i_clock) disable iff (!i_rstn)
        (byte_evt && !wcmd_r && setup_cmd_r == `PWCC_CMD_CLEAR) |=> ##1 (en_map_r == 8'h00);
    endproperty
    a_clear_disables: assert property (p_clear_disables)
        else $error("clear left an event enabled");

    property p_off_disable;
        @(posedge i_clock) disable iff (!i_rstn)
        (ld[0] && wbyte_r == `PWCC_TIME_OFF) |=> ##1 !en_map_r[7];
    endproperty
    a_off_disable: assert property (p_off_disable)
        else $error("disable byte left power off armed");

    property p_off_now;
        @(posedge i_clock) disable iff (!i_rstn)
        (ld[0] && wbyte_r == `PWCC_TIME_NOW && setup_cmd_r == `PWCC_CMD_OFF) |-> ##[1:3] o_power_off;
    endproperty
    a_off_now: assert property (p_off_now)
        else $error("immediate power off missing");

    property p_input_wake;
        @(posedge i_clock) disable iff (!i_rstn)
        (in_en_r[0] && in_s2_r[0]) |=> o_power_on;
    endproperty
    a_input_wake: assert property (p_input_wake)
        else $error("input wake not raised");

    property p_any_wake;
        @(posedge i_clock) disable iff (!i_rstn)
        (any_en_r && |in_s2_r[3:0]) |=> o_power_on;
    endproperty
    a_any_wake: assert property (p_any_wake)
        else $error("any input wake not raised");

    property p_every_stays;
        @(posedge i_clock) disable iff (!i_rstn)
        // a zero interval fires once only, so it is left out here
        (fire[3] && en_map_r[4] && !byte_evt
            && $past(tm[3]) != `PWCC_TIME_NOW) |=> en_map_r[4];
    endproperty
    a_every_stays: assert property (p_every_stays)
        else $error("periodic wake lost after firing");

    property p_after_once;
        @(posedge i_clock) disable iff (!i_rstn)
        (fire[2] && !byte_evt) |=> ##1 !en_map_r[5];
    endproperty
    a_after_once: assert property (p_after_once)
        else $error("one-shot wake still armed");

    property p_query_map;
        @(posedge i_clock) disable iff (!i_rstn)
        (byte_evt && wcmd_r && cmd_r == `PWCC_Q_ENABLE) |=> (reply_r == $past(en_map_r));
    endproperty
    a_query_map: assert property (p_query_map)
        else $error("status query reply wrong");

    c_clear: cover property (@(posedge i_clock) disable iff (!i_rstn) ld == 4'hf);
    c_on: cover property (@(posedge i_clock) disable iff (!i_rstn) o_power_on);
    c_off: cover property (@(posedge i_clock) disable iff (!i_rstn) o_power_off);
endmodule

// ---- pwcc_params.svh ----
// constants for the power wake command controller
// assumes inclusion by bare name from the design files
`ifndef PWCC_PARAMS_SVH
`define PWCC_PARAMS_SVH
`define PWCC_I2C_ADDR 7'h2a
`define PWCC_CMD_OFF 8'h81
`define PWCC_CMD_RING 8'h82
`define PWCC_CMD_AFTER 8'h83
`define PWCC_CMD_EVERY 8'h84
`define PWCC_CMD_CLEAR 8'h85
`define PWCC_CMD_ANY_IN 8'h8f
`define PWCC_CMD_IN0 8'h90
`define PWCC_CMD_IN3 8'h93
`define PWCC_Q_OFF 8'h01
`define PWCC_Q_RING 8'h02
`define PWCC_Q_AFTER 8'h03
`define PWCC_Q_EVERY 8'h04
`define PWCC_Q_ENABLE 8'h05
`define PWCC_TIME_NOW 8'h00
`define PWCC_TIME_OFF 8'hff
`define PWCC_TIME_RESET 8'hff
`define PWCC_UNIT_BIT 7
// 64-bit terms: one minute of core cycles does not fit in 32 bits
`define PWCC_MINUTE_S 64'h3c
`define PWCC_HOUR_MIN 60
`define PWCC_CLK_HZ 64'h773_5940
`define PWCC_TICKS_PER_MIN (`PWCC_MINUTE_S * `PWCC_CLK_HZ)
`endif

// ---- pwcc_pkg.sv ----
// types shared by the power wake command controller
// assumes pwcc_params.svh is available
package pwcc_pkg;
    typedef enum logic [1:0] {
        PWCC_IDLE = 2'b00,
        PWCC_ADDR = 2'b01,
        PWCC_DATA = 2'b11,
        PWCC_READ = 2'b10
    } pwcc_i2c_state_t;
endpackage

// ---- pwcc_timer.sv ----
// one event delay counter in minutes and hours
// assumes a one-cycle minute tick from the parent
`timescale 1ns/1ps
`include "pwcc_params.svh"
module pwcc_timer (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic [7:0] i_time,
    input wire logic i_reload,
    input wire logic i_min_tick,
    output logic o_fire,
    output logic [7:0] o_time
);
    logic [7:0] time_r, time_nxt;
    logic [12:0] left_r, left_nxt;
    logic armed_r, armed_nxt;
    logic fire_r, fire_nxt;

    // minutes left from the unit bit and count
    function automatic logic [12:0] to_min(input logic [7:0] t);
        logic [12:0] v;
        v = {6'h00, t[6:0]};
        if (t[`PWCC_UNIT_BIT]) begin
            v = 13'(v * `PWCC_HOUR_MIN);
        end
        return v;
    endfunction

    // countdown; a load always restarts from the new value
    always_comb begin
        time_nxt = time_r;
        left_nxt = left_r;
        armed_nxt = armed_r;
        fire_nxt = 1'b0;
        if (i_load) begin
            time_nxt = i_time;
            left_nxt = to_min(i_time);
            armed_nxt = (i_time != `PWCC_TIME_OFF);
        end else if (armed_r && left_r == 13'h0000) begin
            fire_nxt = 1'b1;
            left_nxt = to_min(time_r);
            armed_nxt = i_reload && (time_r != `PWCC_TIME_NOW);
        end else if (armed_r && i_min_tick) begin
            left_nxt = 13'(left_r - 13'h0001);
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            time_r <= `PWCC_TIME_RESET;
            left_r <= 13'h0000;
            armed_r <= 1'b0;
            fire_r <= 1'b0;
        end else begin
            time_r <= time_nxt;
            left_r <= left_nxt;
            armed_r <= armed_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign o_fire = fire_r;
    assign o_time = armed_r ? time_r : `PWCC_TIME_OFF;
endmodule

// ---- pwcc_host_model.sv ----
// i2c master standing in for the host processor
// assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/1ps
`include "pwcc_params.svh"
module pwcc_host_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    // quarter of the 125 ns bit period
    localparam realtime QTR = 31.25;
    // scl stands still high outside frames
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // master frames the link
    task automatic start_c();
        o_sda_oe = 1'b1;
        #QTR;
        o_scl = 1'b0;
        #QTR;
    endtask
    task automatic stop_c();
        o_sda_oe = 1'b1;
        #QTR;
        o_scl = 1'b1;
        #QTR;
        o_sda_oe = 1'b0;
        #(2 * QTR);
    endtask
    // sda only moves while scl is low; a 1 releases the line
    task automatic bit_c(input logic b, output logic s);
        o_sda_oe = ~b;
        #QTR;
        o_scl = 1'b1;
        #QTR;
        s = i_sda;
        #QTR;
        o_scl = 1'b0;
        #QTR;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic byte_c(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], s);
            r[i] = s;
        end
        bit_c(1'b1, ack);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // command byte then time byte
    task automatic setup(input logic [7:0] cmd, input logic [7:0] t, output logic nak);
        logic [7:0] r;
        logic a0, a1, a2;
        start_c();
        byte_c({`PWCC_I2C_ADDR, 1'b0}, r, a0);
        byte_c(cmd, r, a1);
        byte_c(t, r, a2);
        stop_c();
        nak = a0 | a1 | a2;
    endtask
    // query byte, pause, one byte read then nack
    task automatic query(input logic [7:0] q, output logic [7:0] d, output logic nak);
        logic [7:0] r;
        logic a0, a1, a2, dn;
        start_c();
        byte_c({`PWCC_I2C_ADDR, 1'b0}, r, a0);
        byte_c(q, r, a1);
        stop_c();
        #1000;
        start_c();
        byte_c({`PWCC_I2C_ADDR, 1'b1}, r, a2);
        byte_c(8'hff, d, dn);
        stop_c();
        nak = a0 | a1 | a2;
    endtask
    task automatic probe(input logic [6:0] a, output logic nak);
        logic [7:0] r;
        start_c();
        byte_c({a, 1'b0}, r, nak);
        stop_c();
    endtask
endmodule

// ---- pwcc_top_tb_top.sv ----
// self-checking bench for the power wake command controller
// assumes the host model drives scl and its share of sda
`timescale 1ns/1ps
module pwcc_top_tb_top;
    // short minute keeps timed events inside the run
    localparam int T = 100;
    logic i_clock, i_rstn, i_ring, o_sda, o_sda_oe, o_power_off, o_power_on;
    logic scl, m_oe, sda, nak;
    logic [3:0] i_wake_in;
    logic [7:0] o_enable_map, d;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n, m;
    int n_on = 0;
    int n_off = 0;
    // pulse counters catch one-cycle outputs that fall inside a transfer
    always @(posedge i_clock) begin
        if (o_power_on === 1'b1) begin
            n_on <= n_on + 1;
        end
        if (o_power_off === 1'b1) begin
            n_off <= n_off + 1;
        end
    end
    // pull-up wire, low while either side pulls
    assign sda = ~m_oe & (o_sda_oe ? o_sda : 1'b1);
    pwcc_top #(.TICKS_PER_MIN(T)) uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_scl(scl),
        .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_ring(i_ring),
        .i_wake_in(i_wake_in), .o_power_off(o_power_off), .o_power_on(o_power_on),
        .o_enable_map(o_enable_map));
    pwcc_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic win(input int v, input int lo, input int hi);
        cmp_count++;
        if (v < lo || v > hi) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    // bounded wait for a power output to reach a level
    task automatic wait_lvl(input bit off, input logic lvl, input int bound, output int c);
        logic v;
        c = 0;
        while (c < bound) begin
            @(posedge i_clock);
            #1;
            c++;
            v = off ? o_power_off : o_power_on;
            if (v === lvl) return;
        end
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, v, lvl);
        summarize();
    endtask
    task automatic set(input logic [7:0] c, input logic [7:0] t);
        host.setup(c, t, nak);
        chk(nak, 1'b0);
    endtask
    // the map lands a few core cycles after the time byte, before stop
    task automatic settle();
        repeat (10) @(posedge i_clock);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({o_power_off, o_power_on, o_sda_oe}, 8'h00);
        chk(o_enable_map, 8'h00);
        host.probe(7'h15, nak);
        chk(nak, 1'b1);
    endtask
    task automatic t_hours();
        set(8'h81, 8'h82);
        set(8'h82, 8'h81);
        set(8'h83, 8'h85);
        settle();
        chk(o_enable_map, 8'he0);
        host.query(8'h01, d, nak);
        chk(d, 8'h82);
        chk(nak, 1'b0);
        host.query(8'h02, d, nak);
        chk(d, 8'h81);
        host.query(8'h03, d, nak);
        chk(d, 8'h85);
        set(8'h85, 8'h00);
    endtask
    task automatic t_off_timed();
        m = n_off;
        set(8'h81, 8'h00);
        settle();
        chk(8'(n_off - m), 8'h01);
        set(8'h81, 8'h05);
        wait_lvl(1'b1, 1'b1, 5 * T + 20, n);
        win(n, 4 * T - 50, 5 * T + 10);
        wait_lvl(1'b1, 1'b0, 1, n);
    endtask
    task automatic t_now_replace();
        m = n_on;
        set(8'h83, 8'h00);
        settle();
        chk(8'(n_on - m), 8'h01);
        set(8'h85, 8'h00);
        wait_lvl(1'b0, 1'b0, 20, n);
        set(8'h83, 8'h0a);
        set(8'h83, 8'h03);
        wait_lvl(1'b0, 1'b1, 3 * T + 20, n);
        win(n, 2 * T - 50, 3 * T + 10);
        set(8'h85, 8'h00);
        wait_lvl(1'b0, 1'b0, 20, n);
    endtask
    task automatic t_periodic();
        set(8'h84, 8'h0a);
        settle();
        chk(o_enable_map, 8'h10);
        set(8'h84, 8'hff);
        settle();
        chk(o_enable_map, 8'h00);
        host.query(8'h04, d, nak);
        chk(d, 8'hff);
        set(8'h84, 8'h02);
        wait_lvl(1'b0, 1'b1, 2 * T + 20, n);
        wait_lvl(1'b0, 1'b0, 2 * T, n);
        wait_lvl(1'b0, 1'b1, 3 * T, m);
        win(n + m, 2 * T - 2, 2 * T + 2);
        set(8'h84, 8'hff);
    endtask
    // input wake commands only get 00h or ffh
    task automatic t_inputs();
        for (int i = 0; i < 4; i++) begin
            set(8'h90 + i[7:0], 8'h00);
            settle();
            chk(o_enable_map, 8'h01 << i);
            @(posedge i_clock);
            i_wake_in[i] <= 1'b1;
            wait_lvl(1'b0, 1'b1, 10, n);
            i_wake_in[i] <= 1'b0;
            wait_lvl(1'b0, 1'b0, 10, n);
            set(8'h90 + i[7:0], 8'hff);
        end
        set(8'h8f, 8'h00);
        settle();
        chk(o_enable_map, 8'h0f);
        @(posedge i_clock);
        i_wake_in <= 4'h4;
        wait_lvl(1'b0, 1'b1, 10, n);
        i_wake_in <= 4'h0;
        host.query(8'h05, d, nak);
        chk(d, 8'h0f);
    endtask
    // modem taken as powered before ring arming
    task automatic t_ring_clear();
        set(8'h82, 8'h00);
        settle();
        chk(o_enable_map, 8'h4f);
        @(posedge i_clock);
        i_ring <= 1'b1;
        wait_lvl(1'b0, 1'b1, 10, n);
        i_ring <= 1'b0;
        set(8'h85, 8'h55);
        settle();
        chk(o_enable_map, 8'h00);
        host.query(8'h05, d, nak);
        chk(d, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rstn = 1'b0;
        i_ring = 1'b0;
        i_wake_in = 4'h0;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        t_reset();
        t_hours();
        t_off_timed();
        t_now_replace();
        t_periodic();
        t_inputs();
        t_ring_clear();
        summarize();
    end
endmodule
